// *** src/i2c_match_pkg.sv ***
package i2c_match_pkg;

  // Number of own-address slots, each paired with one ignore mask
  localparam int SLOTS = 4;

  // Register offsets (byte addresses on the register port)
  localparam logic [7:0] OFF_MON_CTRL = 8'h1c;
  localparam logic [7:0] OFF_CAPTURE = 8'h2c;
  localparam logic [7:0] OFF_CTRL = 8'h44;
  localparam logic [7:0] OFF_STATUS = 8'h48;
  localparam logic [7:0] OFF_SHIFT = 8'h4c;
  // Own-address slot 0..3 and ignore mask 0..3, slot index in the low entry
  localparam logic [SLOTS-1:0][7:0] OWN_OFFS = {8'h28, 8'h24, 8'h20, 8'h40};
  localparam logic [SLOTS-1:0][7:0] IGNORE_OFFS = {8'h3c, 8'h38, 8'h34, 8'h30};

  // Field positions
  localparam int MON_EN_BIT = 0;
  localparam int MON_SCL_BIT = 1;
  localparam int MON_ANY_BIT = 2;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ACK_BIT = 1;
  localparam int ST_ATTN_BIT = 0;
  localparam int ST_ARB_BIT = 1;
  localparam int ST_ADDRESSED_BIT = 2;
  localparam int ST_READ_BIT = 3;
  localparam int GC_BIT = 0;
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;

  // Bit counter value of the ninth (acknowledge) bit of a byte
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // General-call address, compared on all seven bits
  localparam logic [6:0] GENERAL_CALL = 7'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Register port request, one cycle per strobe
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  // One own-address slot with its paired ignore mask (mask bits 7:1 only)
  typedef struct packed {
    logic [7:0] own;
    logic [6:0] ignore;
  } addr_slot_s;

  // Position within a transfer as seen from the bus
  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_ADDR,
    LINK_WRITE,
    LINK_READ,
    LINK_IGNORE
  } link_state_e;

  // Zero-extend a byte to a register word
  function automatic logic [31:0] byte_word(input logic [7:0] b);
    return {24'h000000, b};
  endfunction : byte_word

endpackage : i2c_match_pkg

// *** src/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Asynchronous inputs and their synchronised copies
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs at least one bit");
  end

  // Two flops; the first is read by the second only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '1;
      dout <= '1;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end

endmodule : pin_sync

// *** src/address_matcher.sv ***
`timescale 1ns/1ps
module address_matcher import i2c_match_pkg::*; #(
  parameter int NSLOT = SLOTS
) (
  // Programmed slots
  input wire addr_slot_s [NSLOT-1:0] slots,
  // Received seven-bit address
  input wire logic [6:0] rx_addr,
  // Mode inputs
  input wire logic master_active,
  input wire logic monitor_enable,
  input wire logic match_any,
  // Result
  output logic hit
);

  if (NSLOT < 1) begin : g_bad_slots
    $error("address_matcher needs at least one slot");
  end

  // Pure comparison; the caller samples it at the ninth bit
  always_comb begin
    hit = 1'b0;
    if (!master_active) begin
      for (int i = 0; i < NSLOT; i++) begin
        // General call ignores the mask, all seven bits compared
        if (slots[i].own[GC_BIT] && rx_addr == GENERAL_CALL) begin
          hit = 1'b1;
        end
        // A zeroed slot is disabled; masked bits drop out of the compare
        if (slots[i].own != BYTE_RESET &&
            ((slots[i].own[ADDR_MSB:ADDR_LSB] ^ rx_addr) & ~slots[i].ignore) == 7'h00) begin
          hit = 1'b1;
        end
      end
      // Match-any only counts while monitoring
      if (monitor_enable && match_any) begin
        hit = 1'b1;
      end
    end
  end

endmodule : address_matcher

// *** src/i2c_slave_match_monitor.sv ***
// Function
// - While monitoring, flag an address match; match-any makes every address match.
// - After a match, flag every received or supposedly transmitted data byte.
// - In a monitored read the shift register holds the bus data of the real slave.
// - In monitor mode never answer a read nor drive an acknowledge.
// - Own-address registers are read/write and ignored while acting as master.
// - Own-address bit 0 enables recognition of the all-zero general-call address.
// - A zero own-address register matches nothing; reset clears all four.
// - Own-address bits 7 to 1 hold the seven-bit slave address.
// - Upper eight shift bits go to the captured byte after every nine bits.
// - Captured byte is eight-bit, read-only, reset zero, readable in every mode.
// - The shift data register keeps its normal behaviour and remains readable.
// - Set ignore-mask bits 7 to 1 drop that address bit from the compare.
// - Ignore masks never affect general-call detection.
// - Masks reset to zero; mask bit 0 and bits 31 to 8 read zero.
// - Monitoring without clock drive never stretches the clock.
// - Monitor enable forces data released, clock too unless clock drive set.
// - Clock drive and match-any have no effect while monitor enable is clear.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module i2c_slave_match_monitor import i2c_match_pkg::*; #(
  parameter int NSLOT = SLOTS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire bus_req_s bus_req,
  output logic [31:0] rd_data,
  // Master sequencer state from the neighbouring logic
  input wire logic master_active,
  // Clock pin
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  // Data pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Status
  output logic attention,
  output logic arb_lost
);

  if (NSLOT != SLOTS) begin : g_bad_slots
    $error("register map serves exactly four address slots");
  end

  // The matcher compares the seven address bits that sit above the general-call bit
  if (ADDR_MSB - ADDR_LSB != $bits(GENERAL_CALL) - 1 || GC_BIT >= ADDR_LSB) begin : g_bad_fields
    $error("own-address field must be seven bits above the general-call bit");
  end

  // Control fields must fall inside the bits that are stored
  if (MON_EN_BIT > 2 || MON_SCL_BIT > 2 || MON_ANY_BIT > 2 ||
      CTRL_EN_BIT > 1 || CTRL_ACK_BIT > 1) begin : g_bad_ctrl
    $error("control field outside the stored bits");
  end

  // The bit counter must reach the acknowledge slot and still count past it
  if (ACK_SLOT == 4'h0 || ACK_SLOT == 4'hf) begin : g_bad_ack
    $error("acknowledge slot outside the bit counter");
  end

  // Two registers on one offset would make the read answer ambiguous
  for (genvar g = 0; g < SLOTS; g++) begin : g_offsets
    if (OWN_OFFS[g] == IGNORE_OFFS[g] || OWN_OFFS[g] == OFF_CAPTURE ||
        IGNORE_OFFS[g] == OFF_CAPTURE) begin : g_clash
      $error("slot offset collides with another register");
    end
  end

  // Complete state of the block
  typedef struct packed {
    // Position in the frame and the bits seen on the bus
    link_state_e link;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] capture;
    logic rw;
    logic scl_prev;
    logic sda_prev;
    // Software-visible settings and flags
    logic [2:0] mon_ctrl;
    logic [1:0] ctrl;
    addr_slot_s [SLOTS-1:0] slot;
    logic attn;
    logic arb;
    // Pin drive and register answer
    logic pin_level;
    logic scl_oe_n;
    logic sda_oe_n;
    logic [31:0] rd_data;
  } core_s;

  core_s r_reg;
  core_s r_next;

  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic hit;
  logic mon_en;
  logic mon_scl;
  logic mon_any;

  // One-hot select of the slot whose offset matches; own addresses and masks share the decode
  function automatic logic [SLOTS-1:0] slot_select(input logic [7:0] a, input logic [SLOTS-1:0][7:0] offs);
    logic [SLOTS-1:0] sel;
    sel = '0;
    for (int i = 0; i < SLOTS; i++) begin
      sel[i] = (a == offs[i]);
    end
    return sel;
  endfunction : slot_select

  // Data edge while the clock stays high: falling is a start, rising a stop
  function automatic logic data_edge_high(input logic scl_was, input logic scl_now, input logic sda_was,
    input logic sda_now, input logic rising);
    return scl_was && scl_now && (sda_was != sda_now) && (sda_now == rising);
  endfunction : data_edge_high

  // Data line pull the slave side wants, before monitor gating
  function automatic logic slave_pull(input link_state_e link, input logic [3:0] cnt, input logic addr_hit,
    input logic ack_en, input logic tx_bit);
    logic want;
    want = 1'b0;
    unique case (link)
      LINK_ADDR: want = (cnt == ACK_SLOT) && addr_hit && ack_en;
      LINK_WRITE: want = (cnt == ACK_SLOT) && ack_en;
      // A read drives the zeros of its byte and leaves ones to the pull-up
      LINK_READ: want = (cnt != ACK_SLOT) && !tx_bit;
      LINK_IGNORE: want = 1'b0;
      LINK_IDLE: want = 1'b0;
    endcase
    return want;
  endfunction : slave_pull

  // Status word: two sticky flags and two read-only views of the link
  function automatic logic [31:0] status_word(input logic attn, input logic arb, input logic addr_bit,
    input logic rd_bit);
    logic [31:0] w;
    w = '0;
    w[ST_ATTN_BIT] = attn;
    w[ST_ARB_BIT] = arb;
    w[ST_ADDRESSED_BIT] = addr_bit;
    w[ST_READ_BIT] = rd_bit;
    return w;
  endfunction : status_word

  // Both bus lines cross into the clock domain here
  pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din({scl_i, sda_i}),
    .dout(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Clock drive is gated by monitor enable here; match-any is gated by it inside the matcher
  assign mon_en = r_reg.mon_ctrl[MON_EN_BIT];
  assign mon_scl = mon_en & r_reg.mon_ctrl[MON_SCL_BIT];
  assign mon_any = r_reg.mon_ctrl[MON_ANY_BIT];

  // The address byte sits in the shift register after the eighth bit
  address_matcher #(
    .NSLOT(SLOTS)
  ) u_match (
    .slots(r_reg.slot),
    .rx_addr(r_reg.shift[ADDR_MSB:ADDR_LSB]),
    .master_active(master_active),
    .monitor_enable(mon_en),
    .match_any(mon_any),
    .hit(hit)
  );

  // Next-state logic: register port first, bus events after so they win
  always_comb begin
    logic scl_rise;
    logic start_c;
    logic stop_c;
    logic addressed;
    logic may_stretch;
    logic pull;
    logic [SLOTS-1:0] own_sel;
    logic [SLOTS-1:0] ignore_sel;
    scl_rise = scl_s & ~r_reg.scl_prev;
    start_c = data_edge_high(r_reg.scl_prev, scl_s, r_reg.sda_prev, sda_s, 1'b0);
    stop_c = data_edge_high(r_reg.scl_prev, scl_s, r_reg.sda_prev, sda_s, 1'b1);
    own_sel = slot_select(bus_req.addr, OWN_OFFS);
    ignore_sel = slot_select(bus_req.addr, IGNORE_OFFS);
    addressed = (r_reg.link == LINK_WRITE) || (r_reg.link == LINK_READ);
    // Without clock drive a monitoring device cannot hold the clock
    may_stretch = !mon_en || mon_scl;
    pull = 1'b0;

    r_next = r_reg;
    r_next.scl_prev = scl_s;
    r_next.sda_prev = sda_s;
    r_next.rd_data = '0;

    // Register writes
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        OFF_MON_CTRL: r_next.mon_ctrl = bus_req.wdata[2:0];
        OFF_CTRL: r_next.ctrl = bus_req.wdata[1:0];
        OFF_SHIFT: r_next.shift = bus_req.wdata[7:0];
        OFF_STATUS: begin
          // Write one to clear; a same-cycle event sets it again below
          if (bus_req.wdata[ST_ATTN_BIT]) begin
            r_next.attn = 1'b0;
          end
          if (bus_req.wdata[ST_ARB_BIT]) begin
            r_next.arb = 1'b0;
          end
        end
        default: begin
          for (int i = 0; i < SLOTS; i++) begin
            if (own_sel[i]) begin
              r_next.slot[i].own = bus_req.wdata[7:0];
            end
            if (ignore_sel[i]) begin
              r_next.slot[i].ignore = bus_req.wdata[ADDR_MSB:ADDR_LSB];
            end
          end
        end
      endcase
    end

    // Register reads, answered in the next cycle; unmapped reads give zero
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFF_MON_CTRL: r_next.rd_data = {29'h0, r_reg.mon_ctrl};
        OFF_CTRL: r_next.rd_data = {30'h0, r_reg.ctrl};
        OFF_CAPTURE: r_next.rd_data = byte_word(r_reg.capture);
        OFF_SHIFT: r_next.rd_data = byte_word(r_reg.shift);
        OFF_STATUS: r_next.rd_data = status_word(r_reg.attn, r_reg.arb, addressed, r_reg.rw);
        default: begin
          for (int i = 0; i < SLOTS; i++) begin
            if (own_sel[i]) begin
              r_next.rd_data = byte_word(r_reg.slot[i].own);
            end
            if (ignore_sel[i]) begin
              r_next.rd_data = byte_word({r_reg.slot[i].ignore, 1'b0});
            end
          end
        end
      endcase
    end

    // Bus framing and bit handling
    // A start inside a byte restarts the address phase; a stop ends even a frame cut short
    if (!r_reg.ctrl[CTRL_EN_BIT]) begin
      r_next.link = LINK_IDLE;
      r_next.bitcnt = 4'h0;
    end else if (start_c) begin
      // Start or repeated start opens an address byte
      r_next.link = LINK_ADDR;
      r_next.bitcnt = 4'h0;
    end else if (stop_c) begin
      r_next.link = LINK_IDLE;
      r_next.bitcnt = 4'h0;
    end else if (scl_rise && r_reg.link != LINK_IDLE) begin
      if (r_reg.bitcnt != ACK_SLOT) begin
        // Bus level is shifted in, so a read holds what was really sent
        r_next.shift = {r_reg.shift[6:0], sda_s};
        r_next.bitcnt = r_reg.bitcnt + 4'h1;
        // A one that we meant to send but found low: another party won
        if (r_reg.link == LINK_READ && r_reg.shift[7] && !sda_s) begin
          r_next.arb = 1'b1;
        end
      end else begin
        // Ninth bit sampled now: the byte of this frame is captured
        r_next.bitcnt = 4'h0;
        r_next.capture = r_reg.shift;
        unique case (r_reg.link)
          LINK_ADDR: begin
            if (hit) begin
              r_next.attn = 1'b1;
              r_next.rw = r_reg.shift[0];
              r_next.link = r_reg.shift[0] ? LINK_READ : LINK_WRITE;
            end else begin
              r_next.link = LINK_IGNORE;
            end
          end
          LINK_WRITE: r_next.attn = 1'b1;
          LINK_READ: begin
            r_next.attn = 1'b1;
            // Master declined further bytes
            if (sda_s) begin
              r_next.link = LINK_IGNORE;
            end
          end
          LINK_IGNORE: r_next.link = LINK_IGNORE;
          LINK_IDLE: r_next.link = LINK_IDLE;
        endcase
      end
    end

    // Hold the clock low while software owes an answer
    // Stretching starts only once the clock is already low, so no high phase is cut short
    r_next.scl_oe_n = !(r_reg.attn && addressed && may_stretch && (!scl_s || !r_reg.scl_oe_n));

    // Data line changes only while the clock is low, except the release when the block is disabled
    if (!scl_s) begin
      pull = slave_pull(r_reg.link, r_reg.bitcnt, hit, r_reg.ctrl[CTRL_ACK_BIT], r_reg.shift[7]);
      // Monitoring never drives data or acknowledge
      r_next.sda_oe_n = !(pull && !mon_en);
    end
    if (!r_reg.ctrl[CTRL_EN_BIT]) begin
      r_next.sda_oe_n = 1'b1;
    end
    r_next.pin_level = 1'b0;
  end

  // State register; both pins released, previous pin levels high and all other fields zero after reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
      r_reg.scl_oe_n <= 1'b1;
      r_reg.sda_oe_n <= 1'b1;
      r_reg.scl_prev <= 1'b1;
      r_reg.sda_prev <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign rd_data = r_reg.rd_data;
  assign scl_o = r_reg.pin_level;
  assign sda_o = r_reg.pin_level;
  assign scl_oe_n = r_reg.scl_oe_n;
  assign sda_oe_n = r_reg.sda_oe_n;
  assign attention = r_reg.attn;
  assign arb_lost = r_reg.arb;

endmodule : i2c_slave_match_monitor

// *** testbench/i2c_slave_match_monitor_props.sv ***
`timescale 1ns/1ps
module i2c_slave_match_monitor_props import i2c_match_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire bus_req_s bus_req,
  input wire logic [31:0] rd_data,
  input wire logic master_active,
  // Pins
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  // Status
  input wire logic attention,
  input wire logic arb_lost
);
  logic [1:0] mon_reg;
  logic st_clr;

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Write of one to the attention bit
  assign st_clr = bus_req.wr && bus_req.addr == OFF_STATUS && bus_req.wdata[0];

  // Shadow of monitor enable and clock drive, as seen on the register port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mon_reg <= 2'h0;
    end else if (bus_req.wr && bus_req.addr == OFF_MON_CTRL) begin
      mon_reg <= bus_req.wdata[1:0];
    end
  end

  // Two cycles of monitor mode, so the write latency never trips these
  chk_sda_quiet: assert property (mon_reg[0] && $past(mon_reg[0]) |-> sda_oe_n)
    else $error("Data line pulled while monitoring");
  chk_scl_free: assert property (mon_reg == 2'h1 && $past(mon_reg) == 2'h1 |-> scl_oe_n)
    else $error("Clock stretched without clock drive");
  chk_rd_gap: assert property (!bus_req.rd |=> rd_data == 32'h0)
    else $error("Read data outside its slot");
  chk_cap_word: assert property (bus_req.rd && bus_req.addr == OFF_CAPTURE |=> rd_data[31:8] == 24'h0)
    else $error("Captured byte wider than eight bits");
  chk_mask_read: assert property (bus_req.rd && bus_req.addr[7:4] == 4'h3 && bus_req.addr[1:0] == 2'h0
    |=> rd_data[31:8] == 24'h0 && !rd_data[0])
    else $error("Ignore mask unused bits not zero");
  chk_own_echo: assert property (bus_req.wr && bus_req.addr == OWN_OFFS[1] ##1 !bus_req.wr ##1
    bus_req.rd && bus_req.addr == OWN_OFFS[1] |=> rd_data == {24'h0, $past(bus_req.wdata[7:0], 3)})
    else $error("Own address does not read back");
  chk_attn_sticky: assert property (attention && !st_clr |=> attention)
    else $error("Attention dropped without a clear");
  chk_stretch_end: assert property ($fell(attention) |=> scl_oe_n)
    else $error("Clock held after attention cleared");

  // Main scenarios reached
  cover property ($rose(attention));
  cover property ($fell(scl_oe_n));
  cover property (bus_req.rd && bus_req.addr == OFF_CAPTURE);
endmodule : i2c_slave_match_monitor_props

bind i2c_slave_match_monitor i2c_slave_match_monitor_props chk_i (.clk(clk), .arst_n(arst_n), .bus_req(bus_req),
  .rd_data(rd_data), .master_active(master_active), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .attention(attention), .arb_lost(arb_lost));

// *** testbench/i2c_bus_master_model.sv ***
`timescale 1ns/1ps
module i2c_bus_master_model (
  // Resolved line levels
  input wire logic scl_w,
  input wire logic sda_w,
  // Open-drain pulls, low pulls the line
  output logic scl_drv,
  output logic sda_drv
);
  localparam time HALF = 40ns;

  // Lines idle high on their pull-ups; clock stands still between frames
  initial begin
    scl_drv = 1'h1;
    sda_drv = 1'h1;
  end

  // Release the clock and wait, bounded, while a slave stretches it
  task automatic rise();
    scl_drv = 1'h1;
    for (int i = 0; i < 500 && !scl_w; i++) #10;
    #HALF;
  endtask : rise

  task automatic start();
    sda_drv = 1'h0;
    #HALF;
    scl_drv = 1'h0;
    #(HALF / 2);
  endtask : start

  // Eight bits MSB first, then the acknowledge slot; data moves only while clock low
  task automatic xfer(input logic [7:0] b, input logic ack);
    logic [8:0] bits;
    bits = {b, ack};
    for (int i = 8; i >= 0; i--) begin
      sda_drv = bits[i];
      #(HALF / 2);
      rise();
      scl_drv = 1'h0;
      #(HALF / 2);
    end
  endtask : xfer

  task automatic stop();
    sda_drv = 1'h0;
    #(HALF / 2);
    rise();
    sda_drv = 1'h1;
    #HALF;
  endtask : stop
endmodule : i2c_bus_master_model

// *** testbench/i2c_slave_match_monitor_bench.sv ***
`timescale 1ns/1ps
module i2c_slave_match_monitor_bench;
  import i2c_match_pkg::*;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  bus_req_s bus_req = '0;
  logic master_active = 1'h0;
  logic [31:0] rd_data;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, attention, arb_lost, m_scl, m_sda;
  wire logic scl_w = m_scl & (scl_oe_n | scl_o);
  wire logic sda_w = m_sda & (sda_oe_n | sda_o);
  int miscompares = 0;
  int n_checks = 0;
  // Address cases: mode, slot, own address, mask, address byte, master busy, expected hit
  logic [7:0] t_mon [9] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h04, 8'h05};
  int t_slot [9] = '{1, 1, 1, 1, 2, 0, 1, 1, 1};
  logic [7:0] t_own [9] = '{8'ha4, 8'ha4, 8'ha4, 8'h00, 8'h01, 8'h5a, 8'ha4, 8'h00, 8'h00};
  logic [7:0] t_mask [9] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] t_byte [9] = '{8'ha4, 8'ha6, 8'ha6, 8'h00, 8'h00, 8'h5a, 8'ha4, 8'h91, 8'h90};
  logic [8:0] t_mact = 9'h040;
  logic [8:0] t_hit = 9'h135;

  always #5 clk = ~clk;

  i2c_slave_match_monitor dut (.clk(clk), .arst_n(arst_n), .bus_req(bus_req), .rd_data(rd_data),
    .master_active(master_active), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .attention(attention), .arb_lost(arb_lost));
  i2c_bus_master_model m (.scl_w(scl_w), .sda_w(sda_w), .scl_drv(m_scl), .sda_drv(m_sda));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{a, d, 1'h1, 1'h0};
    @(posedge clk);
    bus_req.wr <= 1'h0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus_req <= '{a, 32'h0, 1'h0, 1'h1};
    @(posedge clk);
    bus_req.rd <= 1'h0;
    #1;
    chk($sformatf("register %h", a), exp, rd_data);
  endtask : rd_chk

  task automatic done(input string name);
    $display("Test %s finished", name);
  endtask : done

  task automatic stop_test();
    $display("Checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // Watchdog, far beyond the roughly twelve microseconds the tests need
  initial begin
    #500us;
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'h1;
    for (int i = 0; i < SLOTS; i++) begin
      rd_chk(OWN_OFFS[i], 32'h0);
      rd_chk(IGNORE_OFFS[i], 32'h0);
    end
    wr(OFF_CAPTURE, 32'hffffffff);
    rd_chk(OFF_CAPTURE, 32'h0);
    rd_chk(8'h00, 32'h0);
    chk("pin levels", 32'h0, {30'h0, scl_o, sda_o});
    wr(OWN_OFFS[1], 32'hffffffff);
    rd_chk(OWN_OFFS[1], 32'hff);
    wr(IGNORE_OFFS[1], 32'hffffffff);
    rd_chk(IGNORE_OFFS[1], 32'hfe);
    done("registers");
    // Address recognition, one frame per table row; every row but one runs in monitor mode
    wr(OFF_CTRL, 32'h3);
    for (int c = 0; c < 9; c++) begin
      wr(OFF_MON_CTRL, {24'h0, t_mon[c]});
      wr(OWN_OFFS[t_slot[c]], {24'h0, t_own[c]});
      wr(IGNORE_OFFS[t_slot[c]], {24'h0, t_mask[c]});
      wr(OFF_STATUS, 32'h3);
      @(posedge clk);
      master_active <= t_mact[c];
      m.start();
      m.xfer(t_byte[c], 1'h1);
      @(negedge clk);
      chk("attention", {31'h0, t_hit[c]}, {31'h0, attention});
      rd_chk(OFF_CAPTURE, {24'h0, t_byte[c]});
      rd_chk(OFF_SHIFT, {24'h0, t_byte[c]});
      m.stop();
      @(posedge clk);
      master_active <= 1'h0;
    end
    done("matching");
    // Read by another slave; lost arbitration is simply cleared
    wr(OFF_STATUS, 32'h3);
    m.start();
    m.xfer(8'h91, 1'h0);
    @(negedge clk);
    chk("attention", 32'h1, {31'h0, attention});
    wr(OFF_STATUS, 32'h3);
    m.xfer(8'h3c, 1'h1);
    @(negedge clk);
    chk("attention", 32'h1, {31'h0, attention});
    chk("arb_lost", 32'h1, {31'h0, arb_lost});
    chk("sda_oe_n", 32'h1, {31'h0, sda_oe_n});
    rd_chk(OFF_CAPTURE, 32'h3c);
    rd_chk(OFF_SHIFT, 32'h3c);
    wr(OFF_STATUS, 32'h3);
    m.stop();
    done("monitored read");
    // Clock drive lets the block stretch until attention is cleared
    wr(OFF_MON_CTRL, 32'h3);
    wr(OWN_OFFS[1], 32'ha4);
    m.start();
    m.xfer(8'ha4, 1'h1);
    repeat (6) @(posedge clk);
    #1;
    chk("scl_oe_n", 32'h0, {31'h0, scl_oe_n});
    wr(OFF_STATUS, 32'h1);
    repeat (3) @(posedge clk);
    #1;
    chk("scl_oe_n", 32'h1, {31'h0, scl_oe_n});
    m.stop();
    done("clock drive");
    stop_test();
  end
endmodule : i2c_slave_match_monitor_bench
